// *** pkg/cxe_defs.vh ***
`ifndef CXE_DEFS_VH
`define CXE_DEFS_VH

// register indices on the plain register port
`define CXE_IDX_STATUS 4'h0
`define CXE_IDX_CAUSE 4'h1
`define CXE_IDX_EPC 4'h2
`define CXE_IDX_ERROR_EPC 4'h3
`define CXE_IDX_FAULTING_VADDR 4'h4
`define CXE_IDX_CONTEXT 4'h5
`define CXE_IDX_WIDE_PTE_CONTEXT 4'h6
`define CXE_IDX_ENTRY_HI 4'h7
`define CXE_IDX_ENTRY_LO 4'h8
`define CXE_IDX_RANDOM 4'h9

// status fields
`define CXE_ST_IE 0
`define CXE_ST_EXL 1
`define CXE_ST_ERL 2
`define CXE_ST_KSU 4:3
`define CXE_ST_UX 5
`define CXE_ST_SX 6
`define CXE_ST_KX 7
`define CXE_ST_SR 20
`define CXE_ST_BEV 22
`define CXE_ST_WMASK 64'h0000_0000_0050_00ff
`define CXE_ST_RESET 64'h0000_0000_0040_0004

// cause fields
`define CXE_CA_CODE 6:2
`define CXE_CA_BD 31

// context, wide context and entry-high fields
`define CXE_CTX_VPN 22:4
`define CXE_CTX_WMASK 64'hffff_ffff_ff80_0000
`define CXE_XCTX_VPN 30:4
`define CXE_XCTX_REGION 32:31
`define CXE_XCTX_WMASK 64'hffff_fffe_0000_0000
`define CXE_EH_VPN 39:13
`define CXE_EH_R 63:62
`define CXE_EH_WMASK 64'hc000_00ff_ffff_e0ff

// virtual address slices
`define CXE_VA_VPN32 31:13
`define CXE_VA_VPN64 39:13
`define CXE_VA_REGION 63:62

// exception codes
`define CXE_CODE_TLB_LOAD 5'h02
`define CXE_CODE_TLB_STORE 5'h03
`define CXE_CODE_ADDR_LOAD 5'h04
`define CXE_CODE_ADDR_STORE 5'h05

// privilege modes in the ksu field
`define CXE_MODE_KERNEL 2'h0
`define CXE_MODE_SUPER 2'h1
`define CXE_MODE_USER 2'h2

// access sizes
`define CXE_SIZE_HALF 2'h1
`define CXE_SIZE_WORD 2'h2
`define CXE_SIZE_DWORD 2'h3

// vectors
`define CXE_VEC_RESET 64'hffff_ffff_bfc0_0000
`define CXE_VEC_REFILL_BOOT 64'hffff_ffff_bfc0_0200
`define CXE_VEC_XREFILL_BOOT 64'hffff_ffff_bfc0_0280
`define CXE_VEC_COMMON_BOOT 64'hffff_ffff_bfc0_0380
`define CXE_VEC_REFILL 64'hffff_ffff_8000_0000
`define CXE_VEC_XREFILL 64'hffff_ffff_8000_0080
`define CXE_VEC_COMMON 64'hffff_ffff_8000_0180

`endif

// *** rtl/cxe_pin_sync.v ***
`timescale 1ns/1ps
`default_nettype none

module cxe_pin_sync
(
  input wire clk,
  input wire rst_b,
  input wire pin_b,
  output reg level_b,
  output wire fall,
  output wire rise
);

  reg meta_reg;
  reg sync_reg;

  // pins idle high, so reset to the inactive level to avoid a false edge
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      level_b <= 1'b1;
    end
    else
    begin
      meta_reg <= pin_b;
      sync_reg <= meta_reg;
      level_b <= sync_reg;
    end
  end

  assign fall = level_b & ~sync_reg;
  assign rise = ~level_b & sync_reg;

endmodule
`default_nettype wire

// *** rtl/cxe_addr_check.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"

module cxe_addr_check
(
  input wire [63:0] vaddr,
  input wire [1:0] size,
  input wire fetch,
  input wire load,
  input wire store,
  input wire mapped,
  input wire tlb_hit,
  input wire tlb_valid,
  input wire [1:0] mode,
  input wire kernel_wide_addr,
  input wire supervisor_wide_addr,
  input wire user_wide_addr,
  output wire addr_err,
  output wire refill,
  output wire invalid,
  output wire wide
);

  wire access;
  wire misaligned;
  wire user_seg;
  wire super_seg;
  wire illegal;

  assign access = fetch | load | store;
  assign wide = (mode == `CXE_MODE_USER) ? user_wide_addr :
                (mode == `CXE_MODE_SUPER) ? supervisor_wide_addr : kernel_wide_addr;

  assign misaligned = (size == `CXE_SIZE_DWORD && vaddr[2:0] != 3'h0) ||
                      (size == `CXE_SIZE_WORD && vaddr[1:0] != 2'h0) ||
                      (size == `CXE_SIZE_HALF && vaddr[0] != 1'b0);

  // 32-bit segments are the sign-extended low and sseg windows
  assign user_seg = wide ? (vaddr[63:62] == 2'h0) : (vaddr[63:31] == 33'h0);
  assign super_seg = user_seg | (wide ? (vaddr[63:62] == 2'h1) :
                     (vaddr[63:29] == {32'hffff_ffff, 3'h6}));
  assign illegal = (mode == `CXE_MODE_USER && !user_seg) ||
                   (mode == `CXE_MODE_SUPER && !super_seg);

  assign addr_err = access & (misaligned | illegal);
  // translation faults only count once the address itself is legal
  assign refill = access & ~addr_err & mapped & ~tlb_hit;
  assign invalid = access & ~addr_err & mapped & tlb_hit & ~tlb_valid;

endmodule
`default_nettype wire

// *** rtl/cxe_exception_entry.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"

//Contract
// - soft reset taken after pin released
// - reset and nmi use uncached boot vector
// - error_restart_pc gets restart or branch pc
// - set error level, soft reset, boot select
// - soft reset aborts cache and bus work
// - nmi on falling edge, ignores masks
// - nmi waits for an instruction boundary
// - misalignment or privilege violation raises address error
// - address error: common vector, load/store code
// - address error loads faulting_vaddr
// - exception_pc and delay flag only when exl clear
// - mapped miss raises tlb refill
// - refill vector width from mode wide bit
// - refill with exl set uses common vector
// - tlb faults write load or store code
// - tlb faults load translation registers
// - invalid entry hit raises invalid via common
// - boot select picks vector bank
// - m stage exception beats e stage
module cxe_exception_entry
#(
  parameter TLB_ENTRIES = 32,
  parameter RAND_W = 6
)
(
  input wire clk,
  input wire rst_b,
  input wire soft_reset_pin_b,
  input wire nmi_pin_b,
  input wire m_valid,
  input wire m_boundary,
  input wire [63:0] m_pc,
  input wire m_in_delay_slot,
  input wire [63:0] m_branch_pc,
  input wire m_fetch,
  input wire m_load,
  input wire m_store,
  input wire [1:0] m_size,
  input wire [63:0] m_vaddr,
  input wire m_mapped,
  input wire m_tlb_hit,
  input wire m_tlb_valid,
  input wire e_valid,
  input wire [63:0] e_pc,
  input wire e_in_delay_slot,
  input wire [63:0] e_branch_pc,
  input wire e_fetch,
  input wire e_load,
  input wire e_store,
  input wire [1:0] e_size,
  input wire [63:0] e_vaddr,
  input wire e_mapped,
  input wire e_tlb_hit,
  input wire e_tlb_valid,
  input wire [3:0] reg_addr,
  input wire [63:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [63:0] reg_rdata,
  output reg redirect_valid,
  output reg [63:0] redirect_pc,
  output reg abort_ops
);

  reg [63:0] status_reg;
  reg [63:0] status_next;
  reg [4:0] code_reg;
  reg [4:0] code_next;
  reg bd_reg;
  reg bd_next;
  reg [63:0] epc_reg;
  reg [63:0] epc_next;
  reg [63:0] err_epc_reg;
  reg [63:0] err_epc_next;
  reg [63:0] faulting_vaddr_reg;
  reg [63:0] faulting_vaddr_next;
  reg [63:0] context_reg;
  reg [63:0] context_next;
  reg [63:0] wide_pte_context_reg;
  reg [63:0] wide_pte_context_next;
  reg [63:0] entry_hi_reg;
  reg [63:0] entry_hi_next;
  reg [63:0] entry_lo_reg;
  reg [RAND_W-1:0] random_reg;
  reg nmi_pend_reg;
  reg [63:0] vec;
  reg [63:0] rdata_next;

  wire sr_rise;
  wire nmi_fall;
  wire m_adr;
  wire m_refill;
  wire m_invalid;
  wire m_wide;
  wire e_adr;
  wire e_refill;
  wire e_invalid;
  wire e_wide;
  wire m_exc;
  wire e_exc;
  wire take_sr;
  wire take_nmi;
  wire take_m;
  wire take_e;
  wire take_gen;
  wire exception_level_bit;
  wire boot_vector_select;
  wire [63:0] restart_pc;
  wire [63:0] g_pc;
  wire g_delay;
  wire [63:0] g_branch_pc;
  wire [63:0] g_vaddr;
  wire g_store;
  wire g_adr;
  wire g_refill;
  wire g_wide;
  localparam [31:0] RAND_TOP = TLB_ENTRIES - 1;

  assign exception_level_bit = status_reg[`CXE_ST_EXL];
  assign boot_vector_select = status_reg[`CXE_ST_BEV];

  cxe_pin_sync u_sr_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .pin_b(soft_reset_pin_b),
    .level_b(),
    .fall(),
    .rise(sr_rise)
  );

  cxe_pin_sync u_nmi_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .pin_b(nmi_pin_b),
    .level_b(),
    .fall(nmi_fall),
    .rise()
  );

  cxe_addr_check u_m_check
  (
    .vaddr(m_vaddr),
    .size(m_size),
    .fetch(m_fetch),
    .load(m_load),
    .store(m_store),
    .mapped(m_mapped),
    .tlb_hit(m_tlb_hit),
    .tlb_valid(m_tlb_valid),
    .mode(status_reg[`CXE_ST_KSU]),
    .kernel_wide_addr(status_reg[`CXE_ST_KX]),
    .supervisor_wide_addr(status_reg[`CXE_ST_SX]),
    .user_wide_addr(status_reg[`CXE_ST_UX]),
    .addr_err(m_adr),
    .refill(m_refill),
    .invalid(m_invalid),
    .wide(m_wide)
  );

  cxe_addr_check u_e_check
  (
    .vaddr(e_vaddr),
    .size(e_size),
    .fetch(e_fetch),
    .load(e_load),
    .store(e_store),
    .mapped(e_mapped),
    .tlb_hit(e_tlb_hit),
    .tlb_valid(e_tlb_valid),
    .mode(status_reg[`CXE_ST_KSU]),
    .kernel_wide_addr(status_reg[`CXE_ST_KX]),
    .supervisor_wide_addr(status_reg[`CXE_ST_SX]),
    .user_wide_addr(status_reg[`CXE_ST_UX]),
    .addr_err(e_adr),
    .refill(e_refill),
    .invalid(e_invalid),
    .wide(e_wide)
  );

  assign m_exc = m_valid & (m_adr | m_refill | m_invalid);
  assign e_exc = e_valid & (e_adr | e_refill | e_invalid);

  // soft reset is taken as the pin is released; it does not wait for a boundary
  assign take_sr = sr_rise;
  // nmi ignores ie, exl and erl but still waits for a clean boundary
  assign take_nmi = ~take_sr & nmi_pend_reg & m_boundary;
  assign take_m = ~take_sr & ~take_nmi & m_exc;
  assign take_e = ~take_sr & ~take_nmi & ~m_exc & e_exc;
  assign take_gen = take_m | take_e;

  assign restart_pc = m_in_delay_slot ? m_branch_pc : m_pc;

  assign g_pc = take_e ? e_pc : m_pc;
  assign g_delay = take_e ? e_in_delay_slot : m_in_delay_slot;
  assign g_branch_pc = take_e ? e_branch_pc : m_branch_pc;
  assign g_vaddr = take_e ? e_vaddr : m_vaddr;
  assign g_store = take_e ? e_store : m_store;
  assign g_adr = take_e ? e_adr : m_adr;
  assign g_refill = take_e ? e_refill : m_refill;
  assign g_wide = take_e ? e_wide : m_wide;

  always @*
  begin
    if (take_sr || take_nmi)
      vec = `CXE_VEC_RESET;
    else if (g_refill && !exception_level_bit)
    begin
      if (g_wide)
        vec = boot_vector_select ? `CXE_VEC_XREFILL_BOOT : `CXE_VEC_XREFILL;
      else
        vec = boot_vector_select ? `CXE_VEC_REFILL_BOOT : `CXE_VEC_REFILL;
    end
    else
      vec = boot_vector_select ? `CXE_VEC_COMMON_BOOT : `CXE_VEC_COMMON;
  end

  always @*
  begin
    status_next = status_reg;
    code_next = code_reg;
    bd_next = bd_reg;
    epc_next = epc_reg;
    err_epc_next = err_epc_reg;
    faulting_vaddr_next = faulting_vaddr_reg;
    context_next = context_reg;
    wide_pte_context_next = wide_pte_context_reg;
    entry_hi_next = entry_hi_reg;
    if (reg_wr)
    begin
      case (reg_addr)
        `CXE_IDX_STATUS:
          status_next = reg_wdata & `CXE_ST_WMASK;
        `CXE_IDX_EPC:
          epc_next = reg_wdata;
        `CXE_IDX_ERROR_EPC:
          err_epc_next = reg_wdata;
        `CXE_IDX_CONTEXT:
          context_next = (reg_wdata & `CXE_CTX_WMASK) | (context_reg & ~`CXE_CTX_WMASK);
        `CXE_IDX_WIDE_PTE_CONTEXT:
          wide_pte_context_next = (reg_wdata & `CXE_XCTX_WMASK) | (wide_pte_context_reg & ~`CXE_XCTX_WMASK);
        `CXE_IDX_ENTRY_HI:
          entry_hi_next = reg_wdata & `CXE_EH_WMASK;
        default:
          status_next = status_reg;
      endcase
    end
    // an exception in the same cycle overrides a software write to its fields
    if (take_sr || take_nmi)
    begin
      err_epc_next = restart_pc;
      status_next[`CXE_ST_ERL] = 1'b1;
      status_next[`CXE_ST_SR] = 1'b1;
      status_next[`CXE_ST_BEV] = 1'b1;
    end
    else if (take_gen)
    begin
      if (g_adr)
        code_next = g_store ? `CXE_CODE_ADDR_STORE : `CXE_CODE_ADDR_LOAD;
      else
        code_next = g_store ? `CXE_CODE_TLB_STORE : `CXE_CODE_TLB_LOAD;
      faulting_vaddr_next = g_vaddr;
      if (!exception_level_bit)
      begin
        epc_next = g_delay ? g_branch_pc : g_pc;
        bd_next = g_delay;
      end
      status_next[`CXE_ST_EXL] = 1'b1;
      if (!g_adr)
      begin
        context_next[`CXE_CTX_VPN] = g_vaddr[`CXE_VA_VPN32];
        wide_pte_context_next[`CXE_XCTX_VPN] = g_vaddr[`CXE_VA_VPN64];
        wide_pte_context_next[`CXE_XCTX_REGION] = g_vaddr[`CXE_VA_REGION];
        // address_space_id field is left as is: it already names the faulting space
        entry_hi_next[`CXE_EH_VPN] = g_vaddr[`CXE_VA_VPN64];
        entry_hi_next[`CXE_EH_R] = g_vaddr[`CXE_VA_REGION];
      end
    end
  end

  always @*
  begin
    rdata_next = 64'h0;
    if (reg_rd)
    begin
      case (reg_addr)
        `CXE_IDX_STATUS:
          rdata_next = status_reg;
        `CXE_IDX_CAUSE:
          rdata_next = {32'h0, bd_reg, 24'h0, code_reg, 2'h0};
        `CXE_IDX_EPC:
          rdata_next = epc_reg;
        `CXE_IDX_ERROR_EPC:
          rdata_next = err_epc_reg;
        `CXE_IDX_FAULTING_VADDR:
          rdata_next = faulting_vaddr_reg;
        `CXE_IDX_CONTEXT:
          rdata_next = context_reg;
        `CXE_IDX_WIDE_PTE_CONTEXT:
          rdata_next = wide_pte_context_reg;
        `CXE_IDX_ENTRY_HI:
          rdata_next = entry_hi_reg;
        `CXE_IDX_ENTRY_LO:
          rdata_next = entry_lo_reg;
        `CXE_IDX_RANDOM:
          rdata_next = {{(64-RAND_W){1'b0}}, random_reg};
        default:
          rdata_next = 64'h0;
      endcase
    end
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_reg <= `CXE_ST_RESET;
      code_reg <= 5'h0;
      bd_reg <= 1'b0;
      epc_reg <= 64'h0;
      err_epc_reg <= 64'h0;
      faulting_vaddr_reg <= 64'h0;
      context_reg <= 64'h0;
      wide_pte_context_reg <= 64'h0;
      entry_hi_reg <= 64'h0;
      entry_lo_reg <= 64'h0;
      random_reg <= {RAND_W{1'b0}};
      nmi_pend_reg <= 1'b0;
      reg_rdata <= 64'h0;
      redirect_valid <= 1'b0;
      redirect_pc <= 64'h0;
      abort_ops <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      code_reg <= code_next;
      bd_reg <= bd_next;
      epc_reg <= epc_next;
      err_epc_reg <= err_epc_next;
      faulting_vaddr_reg <= faulting_vaddr_next;
      context_reg <= context_next;
      wide_pte_context_reg <= wide_pte_context_next;
      entry_hi_reg <= entry_hi_next;
      // entry low is left untouched by faults; its content is undefined then
      if (reg_wr && reg_addr == `CXE_IDX_ENTRY_LO)
        entry_lo_reg <= reg_wdata;
      // free-running so the replacement index is always a legal entry
      if (random_reg == {RAND_W{1'b0}})
        random_reg <= RAND_TOP[RAND_W-1:0];
      else
        random_reg <= random_reg - 1'b1;
      // a new falling edge in the take cycle re-arms the request
      nmi_pend_reg <= nmi_fall | (nmi_pend_reg & ~take_nmi);
      reg_rdata <= rdata_next;
      redirect_valid <= take_sr | take_nmi | take_gen;
      redirect_pc <= vec;
      abort_ops <= take_sr;
    end
  end

endmodule
`default_nettype wire

// *** bench/cxe_exception_entry_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"
module cxe_ee_checker
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic soft_reset_pin_b,
  input wire logic nmi_pin_b,
  input wire logic m_valid,
  input wire logic m_boundary,
  input wire logic m_load,
  input wire logic m_store,
  input wire logic [1:0] m_size,
  input wire logic [63:0] m_vaddr,
  input wire logic e_valid,
  input wire logic reg_rd,
  input wire logic [63:0] reg_rdata,
  input wire logic redirect_valid,
  input wire logic [63:0] redirect_pc,
  input wire logic abort_ops
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // a soft reset rise still in the synchroniser may preempt anything, so wait it out
  logic [3:0] sr_high_cnt;
  logic calm;
  assign calm = !m_boundary && sr_high_cnt >= 4'h8;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      sr_high_cnt <= 4'h0;
    else if (!soft_reset_pin_b)
      sr_high_cnt <= 4'h0;
    else if (sr_high_cnt != 4'hf)
      sr_high_cnt <= sr_high_cnt + 4'h1;
  sr_take_a:
    assert property ($rose(soft_reset_pin_b) |-> ##[1:6] abort_ops)
    else $error("soft reset not taken after pin release");
  nmi_take_a:
    assert property ($fell(nmi_pin_b) ##1 (m_boundary && soft_reset_pin_b) [*3]
      |-> ##[0:3] (redirect_valid && redirect_pc == `CXE_VEC_RESET))
    else $error("nmi not taken at a boundary");
  nmi_wait_a:
    assert property ($fell(nmi_pin_b) ##1 (calm && !m_valid && !e_valid) [*6] |-> !redirect_valid)
    else $error("nmi taken off a boundary");
  addr_err_a:
    assert property (m_valid && (m_load || m_store) && m_size == `CXE_SIZE_WORD
      && m_vaddr[1:0] != 2'h0 && calm
      |=> redirect_valid && redirect_pc inside {`CXE_VEC_COMMON, `CXE_VEC_COMMON_BOOT})
    else $error("misaligned word did not reach common vector");
  legal_vec_a:
    assert property (redirect_valid |-> redirect_pc inside {`CXE_VEC_RESET,
      `CXE_VEC_REFILL, `CXE_VEC_XREFILL, `CXE_VEC_COMMON, `CXE_VEC_REFILL_BOOT,
      `CXE_VEC_XREFILL_BOOT, `CXE_VEC_COMMON_BOOT})
    else $error("redirect to an unknown vector");
  idle_quiet_a:
    assert property (!m_valid && !e_valid && calm |=> !redirect_valid)
    else $error("redirect without a cause");
  rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == 64'h0)
    else $error("read data outside its cycle");
  abort_vec_a:
    assert property (abort_ops |-> redirect_valid && redirect_pc == `CXE_VEC_RESET)
    else $error("abort without reset redirect");
  nmi_no_abort_a:
    assert property (abort_ops |-> sr_high_cnt < 4'h8)
    else $error("abort without a soft reset");
  cover property (abort_ops);
  cover property (redirect_valid && redirect_pc == `CXE_VEC_XREFILL);
  cover property (redirect_valid && redirect_pc == `CXE_VEC_COMMON_BOOT);
endmodule
bind cxe_exception_entry cxe_ee_checker cxe_ee_checker_i (.*);
`default_nettype wire

// *** bench/cxe_sys_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
module cxe_sys_ctl
(
  input wire logic clk,
  output logic soft_reset_pin_b,
  output logic nmi_pin_b
);
  // both pins are pulled up on the board, so a released pin reads high
  initial
  begin
    soft_reset_pin_b = 1'b1;
    nmi_pin_b = 1'b1;
  end
  task automatic srst(input int n);
    soft_reset_pin_b <= 1'b0;
    repeat (n) @(posedge clk);
    soft_reset_pin_b <= 1'b1;
  endtask
  task automatic nmi(input int n);
    nmi_pin_b <= 1'b0;
    repeat (n) @(posedge clk);
    nmi_pin_b <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** bench/cxe_exception_entry_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"
module cxe_exception_entry_tb;
  logic clk, rst_b, soft_reset_pin_b, nmi_pin_b, m_boundary, reg_wr, reg_rd;
  logic m_valid, m_in_delay_slot, m_fetch, m_load, m_store, m_mapped, m_tlb_hit, m_tlb_valid;
  logic e_valid, e_in_delay_slot, e_fetch, e_load, e_store, e_mapped, e_tlb_hit, e_tlb_valid;
  logic [63:0] m_pc, m_branch_pc, m_vaddr, e_pc, e_branch_pc, e_vaddr, reg_wdata;
  logic [63:0] reg_rdata, redirect_pc;
  logic [1:0] m_size, e_size;
  logic [3:0] reg_addr;
  logic redirect_valid, abort_ops;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  localparam logic [63:0] VA = 64'hffff_ffff_c000_2000;
  localparam logic [63:0] PC = 64'hffff_ffff_8000_1000;
  localparam logic [63:0] BPC = 64'hffff_ffff_8000_0ffc;
  logic [63:0] st_t [3] = '{64'h0, 64'h80, 64'h40_0000};
  logic [63:0] vec_t [3] = '{`CXE_VEC_REFILL, `CXE_VEC_XREFILL, `CXE_VEC_REFILL_BOOT};
  cxe_exception_entry cxe_exception_entry_i (.*);
  cxe_sys_ctl cxe_sys_ctl_i (.clk(clk), .soft_reset_pin_b(soft_reset_pin_b),
    .nmi_pin_b(nmi_pin_b));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  function automatic logic [63:0] cz(input logic bd, input logic [4:0] c);
    return {32'h0, bd, 24'h0, c, 2'h0};
  endfunction
  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [63:0] e, input string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(n, reg_rdata, e);
    @(posedge clk);
  endtask
  // kind bits are load, store, mapped, hit, valid
  task automatic ms(input logic [4:0] k, input logic [1:0] sz, input logic [63:0] va);
    {m_load, m_store, m_mapped, m_tlb_hit, m_tlb_valid} <= k;
    m_size <= sz;
    m_vaddr <= va;
  endtask
  task automatic go(input logic [63:0] v, input string n);
    m_valid <= 1'b1;
    @(posedge clk);
    m_valid <= 1'b0;
    e_valid <= 1'b0;
    @(negedge clk);
    chk(n, {63'h0, redirect_valid}, 64'h1);
    chk(n, redirect_pc, v);
    @(posedge clk);
  endtask
  task automatic wrv(input logic ab, input string n);
    int k;
    k = 0;
    while (redirect_valid !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    chk(n, {63'h0, redirect_valid}, 64'h1);
    chk(n, redirect_pc, `CXE_VEC_RESET);
    chk(n, {63'h0, abort_ops}, {63'h0, ab});
    @(posedge clk);
    m_valid <= 1'b0;
    m_boundary <= 1'b0;
  endtask
  initial
  begin
    rst_b = 1'b0;
    {m_boundary, reg_wr, reg_rd, m_valid, m_in_delay_slot, m_fetch, e_valid} = '0;
    {e_in_delay_slot, e_fetch, e_load, e_store, e_mapped, e_tlb_hit, e_tlb_valid} = '0;
    {m_pc, m_branch_pc, e_pc, e_branch_pc, e_vaddr, reg_wdata, m_size, e_size} = '0;
    ms(5'h0, 2'h0, 64'h0);
    reg_addr = 4'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(4'h0, 64'h40_0004, "status");
    rd(4'hf, 64'h0, "unmapped");
    wr(4'h1, 64'h7c);
    rd(4'h1, 64'h0, "cause ro");
    $display("test regs done");
    wr(4'h0, 64'h0);
    m_pc <= PC;
    m_branch_pc <= BPC;
    ms(5'b10000, `CXE_SIZE_WORD, 64'hffff_ffff_8000_0102);
    go(`CXE_VEC_COMMON, "ae vec");
    rd(4'h1, cz(1'b0, `CXE_CODE_ADDR_LOAD), "ae code");
    rd(4'h2, PC, "epc");
    rd(4'h4, 64'hffff_ffff_8000_0102, "faulting_vaddr");
    rd(4'h0, 64'h2, "exl");
    m_in_delay_slot <= 1'b1;
    ms(5'b01000, `CXE_SIZE_HALF, 64'hffff_ffff_8000_0201);
    go(`CXE_VEC_COMMON, "ae st vec");
    rd(4'h1, cz(1'b0, `CXE_CODE_ADDR_STORE), "ae st code");
    rd(4'h2, PC, "epc kept");
    wr(4'h0, 64'h8);
    ms(5'b10000, `CXE_SIZE_WORD, PC);
    go(`CXE_VEC_COMMON, "super kseg");
    wr(4'h0, 64'h10);
    go(`CXE_VEC_COMMON, "user kseg");
    rd(4'h1, cz(1'b1, `CXE_CODE_ADDR_LOAD), "user code");
    wr(4'h0, 64'h2);
    $display("test address error done");
    ms(5'b10100, `CXE_SIZE_WORD, VA);
    go(`CXE_VEC_COMMON, "refill exl");
    rd(4'h1, cz(1'b1, `CXE_CODE_TLB_LOAD), "refill code");
    rd(4'h5, {41'h0, VA[31:13], 4'h0}, "context");
    rd(4'h6, {31'h0, VA[63:62], VA[39:13], 4'h0}, "wide context");
    rd(4'h7, {VA[63:62], 22'h0, VA[39:13], 13'h0}, "entry high");
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h0, st_t[i]);
      ms(5'b01100, `CXE_SIZE_WORD, VA);
      go(vec_t[i], "refill vec");
    end
    rd(4'h1, cz(1'b1, `CXE_CODE_TLB_STORE), "bd");
    rd(4'h2, BPC, "epc branch");
    wr(4'h0, 64'h40_0000);
    ms(5'b10110, `CXE_SIZE_WORD, VA);
    go(`CXE_VEC_COMMON_BOOT, "invalid");
    rd(4'h1, cz(1'b1, `CXE_CODE_TLB_LOAD), "invalid code");
    $display("test tlb done");
    {e_valid, e_load} <= 2'h3;
    e_size <= `CXE_SIZE_WORD;
    e_vaddr <= 64'hffff_ffff_8000_0302;
    ms(5'b01100, `CXE_SIZE_WORD, VA + 64'h4000);
    go(`CXE_VEC_COMMON_BOOT, "m wins");
    rd(4'h1, cz(1'b1, `CXE_CODE_TLB_STORE), "m code");
    rd(4'h4, VA + 64'h4000, "m faulting_vaddr");
    $display("test stages done");
    wr(4'h0, 64'h3);
    ms(5'h0, 2'h0, 64'h0);
    cxe_sys_ctl_i.nmi(2);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("nmi early", {63'h0, redirect_valid}, 64'h0);
    @(posedge clk);
    m_valid <= 1'b1;
    m_boundary <= 1'b1;
    wrv(1'b0, "nmi");
    rd(4'h3, BPC, "error_restart_pc branch");
    rd(4'h0, 64'h50_0007, "nmi status");
    m_boundary <= 1'b1;
    cxe_sys_ctl_i.nmi(2);
    wrv(1'b0, "nmi at boundary");
    $display("test nmi done");
    wr(4'h0, 64'h0);
    m_in_delay_slot <= 1'b0;
    m_valid <= 1'b1;
    cxe_sys_ctl_i.srst(3);
    wrv(1'b1, "soft reset");
    rd(4'h3, PC, "error_restart_pc");
    rd(4'h0, 64'h50_0004, "sr status");
    $display("test soft reset done");
    summarize();
  end
endmodule
`default_nettype wire
